// file: core/dspdla_top.sv
// Purpose: Serial port (four-wire and two-wire), DAC double buffer with load strobe, and limit alert.
// Assumes: Serial clock, data, frame select, strobe and select pins are asynchronous and synchronised here.
// Notes: Serial clock must stay well below a quarter of the system clock for edge finding.

`timescale 1ns/1ps

module dspdla_top
	import dspdla_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_sdin,
	output logic o_sdin_o,
	output logic o_sdin_oe,
	output logic o_dout_o,
	output logic o_dout_oe,
	input wire logic [1:0] i_addr_sel,
	input wire logic i_dac_load_strobe_n,
	input wire logic i_cfg_wr,
	input wire logic i_cfg_load_pin_enable,
	input wire logic i_cfg_alert_active_high,
	output logic o_load_pin_enable,
	output logic o_alert_active_high,
	input wire logic i_sw_load,
	input wire dspdla_dac_wr_type i_dac_wr,
	output logic [NUM_DAC-1:0][DAC_W-1:0] o_dac_value,
	output logic [NUM_DAC-1:0] o_pending,
	output logic o_dac_updated,
	input wire logic i_limit_exceeded,
	output logic o_alert_o,
	output logic o_alert_oe,
	input wire logic [BYTE_W-1:0] i_tx_data,
	output dspdla_rx_word_type o_rx_word,
	output logic o_rx_valid,
	input wire logic i_rx_ready,
	output logic o_rx_overrun,
	input wire logic i_overrun_clr,
	output logic [I2C_ADDR_W-1:0] o_i2c_addr,
	output logic o_addr_latched
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] sclk_s_q;
	logic [2:0] cs_s_q;
	logic [2:0] sda_s_q;
	logic [2:0] strobe_s_q;
	logic [1:0] sel_m_q;
	logic [1:0] sel_s_q;

	// Two stages, third stage only for edge finding
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			sclk_s_q <= 3'h7;
			cs_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			strobe_s_q <= 3'h7;
			sel_m_q <= 2'h0;
			sel_s_q <= 2'h0;
		end else begin
			sclk_s_q <= {sclk_s_q[1:0], i_sclk};
			cs_s_q <= {cs_s_q[1:0], i_cs_n};
			sda_s_q <= {sda_s_q[1:0], i_sdin};
			strobe_s_q <= {strobe_s_q[1:0], i_dac_load_strobe_n};
			sel_m_q <= i_addr_sel;
			sel_s_q <= sel_m_q;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic framed;
	logic frame_start;
	logic sda_now;
	logic i2c_mode;
	logic i2c_start;
	logic i2c_stop;
	assign scl_rise = sclk_s_q[1] & ~sclk_s_q[2];
	assign scl_fall = ~sclk_s_q[1] & sclk_s_q[2];
	assign framed = ~cs_s_q[1];
	assign frame_start = ~cs_s_q[1] & cs_s_q[2];
	assign sda_now = sda_s_q[1];
	assign i2c_mode = cs_s_q[1];
	assign i2c_start = i2c_mode & sclk_s_q[1] & sda_s_q[2] & ~sda_s_q[1];
	assign i2c_stop = i2c_mode & sclk_s_q[1] & ~sda_s_q[2] & sda_s_q[1];

	// ----------------------------------------
	// Four-wire engine
	// ----------------------------------------
	logic [2:0] spi_cnt_q;
	logic [BYTE_W-1:0] spi_in_q;
	logic [BYTE_W-1:0] spi_out_q;
	logic spi_oe_q;
	logic spi_byte;
	assign spi_byte = framed & scl_rise & (spi_cnt_q == BIT_LAST[2:0]);

	// Input shift on rising clock while framed
	always_ff @(posedge i_clock) begin
		if (i_reset || !framed) begin
			spi_cnt_q <= '0;
			spi_in_q <= '0;
		end else if (scl_rise) begin
			spi_in_q <= {spi_in_q[BYTE_W-2:0], sda_now};
			spi_cnt_q <= spi_cnt_q + 1'b1;
		end
	end

	// Output shift on falling clock, reload after each byte; open drain pulls low for a zero
	always_ff @(posedge i_clock) begin
		if (i_reset || !framed) begin
			spi_out_q <= '0;
			spi_oe_q <= 1'b0;
		end else if (frame_start) begin
			spi_out_q <= i_tx_data;
			spi_oe_q <= ~i_tx_data[BYTE_W-1];
		end else if (scl_fall) begin
			if (spi_cnt_q == 3'h0) begin
				spi_out_q <= i_tx_data;
				spi_oe_q <= ~i_tx_data[BYTE_W-1];
			end else begin
				spi_out_q <= {spi_out_q[BYTE_W-2:0], 1'b0};
				spi_oe_q <= ~spi_out_q[BYTE_W-2];
			end
		end
	end
	assign o_dout_o = 1'b0;
	assign o_dout_oe = spi_oe_q;

	// ----------------------------------------
	// Two-wire engine
	// ----------------------------------------
	dspdla_i2c_state_type i2c_st_q;
	logic [3:0] i2c_cnt_q;
	logic [BYTE_W-1:0] i2c_sh_q;
	logic [BYTE_W-1:0] i2c_tx_q;
	logic i2c_rw_q;
	logic i2c_nack_q;
	logic i2c_oe_q;
	logic [I2C_ADDR_W-1:0] pin_addr;
	logic [I2C_ADDR_W-1:0] i2c_addr_q;
	logic [1:0] valid_cnt_q;
	logic addr_latched_q;
	logic [I2C_ADDR_W-1:0] cur_addr;
	logic addr_done;
	logic addr_match;
	logic i2c_byte;

	// Address from the three-level select pin
	always_comb begin
		case (sel_s_q)
			ADD_SEL_FLOAT: pin_addr = I2C_ADDR_FLOAT;
			ADD_SEL_HIGH: pin_addr = I2C_ADDR_HIGH;
			default: pin_addr = I2C_ADDR_LOW;
		endcase
	end
	assign cur_addr = addr_latched_q ? i2c_addr_q : pin_addr;
	assign addr_done = (i2c_st_q == I2C_ADDR) & scl_rise & (i2c_cnt_q == BIT_LAST) & ~i2c_start & ~i2c_stop;
	assign addr_match = (i2c_sh_q[I2C_ADDR_W-1:0] == cur_addr);
	assign i2c_byte = (i2c_st_q == I2C_WRITE) & scl_rise & (i2c_cnt_q == BIT_LAST) & ~i2c_start & ~i2c_stop;

	// Bus sequencer: address, acknowledge, write bytes or read bytes
	always_ff @(posedge i_clock) begin
		if (i_reset || !i2c_mode || i2c_stop) begin
			i2c_st_q <= I2C_IDLE;
			i2c_cnt_q <= '0;
			i2c_sh_q <= '0;
			i2c_tx_q <= '0;
			i2c_rw_q <= 1'b0;
			i2c_nack_q <= 1'b0;
			i2c_oe_q <= 1'b0;
		end else if (i2c_start) begin
			i2c_st_q <= I2C_ADDR;
			i2c_cnt_q <= '0;
			i2c_oe_q <= 1'b0;
		end else begin
			case (i2c_st_q)
				I2C_ADDR, I2C_WRITE: begin
					if (scl_rise) begin
						i2c_sh_q <= {i2c_sh_q[BYTE_W-2:0], sda_now};
						i2c_cnt_q <= i2c_cnt_q + 1'b1;
						if (i2c_cnt_q == BIT_LAST) begin
							if (i2c_st_q == I2C_ADDR) begin
								i2c_rw_q <= sda_now;
								i2c_st_q <= addr_match ? I2C_ACK : I2C_IGNORE;
							end else begin
								i2c_st_q <= I2C_ACK;
							end
						end
					end
				end
				I2C_ACK: begin
					if (scl_fall) begin
						if (i2c_cnt_q == BIT_ACK) begin
							i2c_oe_q <= 1'b1;
							i2c_cnt_q <= BIT_ACK_END;
						end else begin
							i2c_cnt_q <= '0;
							if (i2c_rw_q) begin
								i2c_tx_q <= i_tx_data;
								i2c_oe_q <= ~i_tx_data[BYTE_W-1];
								i2c_st_q <= I2C_READ;
							end else begin
								i2c_oe_q <= 1'b0;
								i2c_st_q <= I2C_WRITE;
							end
						end
					end
				end
				I2C_READ: begin
					if (scl_rise) begin
						i2c_cnt_q <= i2c_cnt_q + 1'b1;
						if (i2c_cnt_q == BIT_LAST) begin
							i2c_st_q <= I2C_RACK;
						end
					end else if (scl_fall) begin
						i2c_tx_q <= {i2c_tx_q[BYTE_W-2:0], 1'b0};
						i2c_oe_q <= ~i2c_tx_q[BYTE_W-2];
					end
				end
				I2C_RACK: begin
					if (scl_fall && i2c_cnt_q == BIT_ACK) begin
						i2c_oe_q <= 1'b0;
					end else if (scl_rise) begin
						i2c_nack_q <= sda_now;
						i2c_cnt_q <= BIT_ACK_END;
					end else if (scl_fall) begin
						i2c_cnt_q <= '0;
						i2c_tx_q <= i_tx_data;
						i2c_oe_q <= ~i2c_nack_q & ~i_tx_data[BYTE_W-1];
						i2c_st_q <= i2c_nack_q ? I2C_IGNORE : I2C_READ;
					end
				end
				I2C_IGNORE: i2c_oe_q <= 1'b0;
				default: i2c_st_q <= I2C_IDLE;
			endcase
		end
	end
	assign o_sdin_o = 1'b0;
	assign o_sdin_oe = i2c_oe_q;

	// Address latch on the eighth clock of the second matching addressing
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			valid_cnt_q <= '0;
			addr_latched_q <= 1'b0;
			i2c_addr_q <= I2C_ADDR_LOW;
		end else if (addr_done && addr_match && !addr_latched_q) begin
			if (valid_cnt_q == ADDR_LATCH_COUNT - 2'h1) begin
				addr_latched_q <= 1'b1;
				i2c_addr_q <= pin_addr;
			end else begin
				valid_cnt_q <= valid_cnt_q + 2'h1;
			end
		end
	end
	assign o_i2c_addr = cur_addr;
	assign o_addr_latched = addr_latched_q;

	// ----------------------------------------
	// Received-byte buffering
	// ----------------------------------------
	dspdla_rx_word_type push_word_q;
	logic push_q;
	logic fifo_in_ready;
	logic overrun_q;

	// Register each finished byte for the FIFO
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			push_q <= 1'b0;
			push_word_q <= '0;
		end else begin
			push_q <= spi_byte | i2c_byte;
			if (spi_byte) begin
				push_word_q <= '{from_i2c: 1'b0, data: {spi_in_q[BYTE_W-2:0], sda_now}};
			end else if (i2c_byte) begin
				push_word_q <= '{from_i2c: 1'b1, data: {i2c_sh_q[BYTE_W-2:0], sda_now}};
			end
		end
	end

	// Sticky overrun when a byte meets a full FIFO; a new overrun beats the clear
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			overrun_q <= 1'b0;
		end else if (push_q && !fifo_in_ready) begin
			overrun_q <= 1'b1;
		end else if (i_overrun_clr) begin
			overrun_q <= 1'b0;
		end
	end
	assign o_rx_overrun = overrun_q;

	dspdla_fifo #(
		.WIDTH($bits(dspdla_rx_word_type)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_in_valid(push_q),
		.o_in_ready(fifo_in_ready),
		.i_in_data(push_word_q),
		.o_out_valid(o_rx_valid),
		.i_out_ready(i_rx_ready),
		.o_out_data(o_rx_word)
	);

	// ----------------------------------------
	// Configuration and alert
	// ----------------------------------------
	logic load_pin_en_q;
	logic alert_high_q;
	logic alert_oe_q;

	// Configuration bits written by a strobe
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			load_pin_en_q <= RST_LOAD_PIN_ENABLE;
			alert_high_q <= RST_ALERT_ACTIVE_HIGH;
		end else if (i_cfg_wr) begin
			load_pin_en_q <= i_cfg_load_pin_enable;
			alert_high_q <= i_cfg_alert_active_high;
		end
	end
	assign o_load_pin_enable = load_pin_en_q;
	assign o_alert_active_high = alert_high_q;

	// Open drain pulls low when the pin must read low
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			alert_oe_q <= ~RST_ALERT_ACTIVE_HIGH;
		end else begin
			alert_oe_q <= alert_high_q ? ~i_limit_exceeded : i_limit_exceeded;
		end
	end
	assign o_alert_o = 1'b0;
	assign o_alert_oe = alert_oe_q;

	// ----------------------------------------
	// DAC double buffer
	// ----------------------------------------
	logic strobe_fall;
	logic load_fire;
	logic updated_q;
	assign strobe_fall = ~strobe_s_q[1] & strobe_s_q[2];
	assign load_fire = (strobe_fall & load_pin_en_q) | i_sw_load;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_DAC; ch++) begin : g_dac
			logic [DAC_W-1:0] input_q;
			logic [DAC_W-1:0] dac_q;
			logic pending_q;
			logic wr_hit;
			assign wr_hit = i_dac_wr.valid & (i_dac_wr.sel == DAC_SEL_W'(ch));
			// Input register, pending flag and output register; a write beats the load clear
			always_ff @(posedge i_clock) begin
				if (i_reset) begin
					input_q <= '0;
					dac_q <= '0;
					pending_q <= 1'b0;
				end else begin
					if (load_fire && pending_q) begin
						dac_q <= input_q;
					end
					if (wr_hit) begin
						input_q <= i_dac_wr.data;
						pending_q <= 1'b1;
					end else if (load_fire) begin
						pending_q <= 1'b0;
					end
				end
			end
			assign o_dac_value[ch] = dac_q;
			assign o_pending[ch] = pending_q;
		end
	endgenerate

	// One-cycle pulse after any DAC register changes
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			updated_q <= 1'b0;
		end else begin
			updated_q <= load_fire & (|o_pending);
		end
	end
	assign o_dac_updated = updated_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence seq_last_spi_bit;
		framed && scl_rise && spi_cnt_q == 3'h7;
	endsequence

	AST_SPI_BYTE_PUSH: assert property (@(posedge i_clock) disable iff (i_reset)
		seq_last_spi_bit |=> push_q && !push_word_q.from_i2c && push_word_q.data[0] == $past(sda_now))
		else $error("four-wire byte not pushed");
	AST_DOUT_FALL_ONLY: assert property (@(posedge i_clock) disable iff (i_reset)
		framed && $past(framed) && !scl_fall && !frame_start |=> $stable(o_dout_oe))
		else $error("serial output changed off a falling edge");
	AST_DOUT_RELEASED: assert property (@(posedge i_clock) disable iff (i_reset)
		!framed |=> !o_dout_oe && spi_cnt_q == 3'h0)
		else $error("serial output driven while not framed");
	AST_LOAD_COPIES: assert property (@(posedge i_clock) disable iff (i_reset)
		load_fire && o_pending[0] |=> o_dac_value[0] == $past(g_dac[0].input_q))
		else $error("pending input not copied on load");
	AST_LOAD_ALL: assert property (@(posedge i_clock) disable iff (i_reset)
		load_fire && !i_dac_wr.valid |=> o_pending == '0 ##1 !o_dac_updated)
		else $error("load left some channel pending");
	AST_LOAD_GATED: assert property (@(posedge i_clock) disable iff (i_reset)
		!load_pin_en_q && !i_sw_load |=> $stable(o_dac_value))
		else $error("disabled strobe pin loaded the DAC");
	AST_CFG_DEFAULT: assert property (@(posedge i_clock)
		$past(i_reset) && !i_reset |-> o_load_pin_enable && !o_alert_active_high)
		else $error("reset configuration wrong");
	AST_ALERT: assert property (@(posedge i_clock) disable iff (i_reset)
		i_limit_exceeded && !alert_high_q ##1 !$past(i_cfg_wr) |-> o_alert_oe)
		else $error("active-low alert not pulled low");
	AST_ADDR_MAP: assert property (@(posedge i_clock) disable iff (i_reset)
		!addr_latched_q && sel_s_q == ADD_SEL_HIGH |-> o_i2c_addr == 7'h4b)
		else $error("select pin address map wrong");
	AST_LATCH_SECOND: assert property (@(posedge i_clock) disable iff (i_reset)
		$rose(addr_latched_q) |-> $past(addr_done) && $past(valid_cnt_q) == 2'h1)
		else $error("address latched on wrong addressing");
	AST_ADDR_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
		addr_latched_q |=> addr_latched_q && $stable(o_i2c_addr))
		else $error("latched address changed");

endmodule : dspdla_top

// file: core/dspdla_pkg.sv
// Purpose: Shared constants and carrier types for the serial port, DAC load and alert block.
// Assumes: One system clock at 50 MHz; all pins arrive asynchronous to it.
// Notes: Address select pin level arrives pre-decoded by the pad as low, floating or high.
//
// What this block does
// - In four-wire mode a transfer is framed only while the active-low frame select is held low.
// - While framed, each serial input bit is taken on a rising serial clock edge.
// - The serial output bit changes only at the start and end of a frame and on falling serial clock edges.
// - A falling load strobe edge copies every input register with new data into its DAC register.
// - One load strobe edge updates all pending DAC registers in the same cycle.
// - The load pin enable bit decides whether the load strobe pin may trigger loading.
// - After reset the load pin enable bit is set so the strobe pin controls loading.
// - The open-drain alert asserts on an exceeded limit, polarity selectable, active low by default.
// - The bus address is 1001 000 for a low select pin, 1001 010 floating and 1001 011 high.
// - The pin-selected bus address is not latched until it has been sent on the bus twice.
// - The bus address latches on the eighth clock of the second valid addressing.
// - Once latched, later changes on the select pin leave the bus address unchanged.

package dspdla_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_DAC = 4;
	localparam int DAC_W = 12;
	localparam int DAC_SEL_W = 2;
	localparam int BYTE_W = 8;
	localparam int I2C_ADDR_W = 7;
	localparam int FIFO_DEPTH_DEF = 16;

	// ----------------------------------------
	// Bus address selection
	// ----------------------------------------
	localparam logic [1:0] ADD_SEL_LOW = 2'h0;
	localparam logic [1:0] ADD_SEL_FLOAT = 2'h1;
	localparam logic [1:0] ADD_SEL_HIGH = 2'h2;
	localparam logic [6:0] I2C_ADDR_LOW = 7'h48;
	localparam logic [6:0] I2C_ADDR_FLOAT = 7'h4a;
	localparam logic [6:0] I2C_ADDR_HIGH = 7'h4b;
	localparam logic [1:0] ADDR_LATCH_COUNT = 2'h2;

	// ----------------------------------------
	// Bit counter marks
	// ----------------------------------------
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_ACK_END = 4'h9;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic RST_LOAD_PIN_ENABLE = 1'b1;
	localparam logic RST_ALERT_ACTIVE_HIGH = 1'b0;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic [DAC_SEL_W-1:0] sel;
		logic [DAC_W-1:0] data;
	} dspdla_dac_wr_type;

	typedef struct packed {
		logic from_i2c;
		logic [BYTE_W-1:0] data;
	} dspdla_rx_word_type;

	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_ACK,
		I2C_WRITE,
		I2C_READ,
		I2C_RACK,
		I2C_IGNORE
	} dspdla_i2c_state_type;

endpackage : dspdla_pkg

// file: core/dspdla_fifo.sv
// Purpose: Received-byte FIFO between the serial engines and the user side.
// Assumes: Single clock; push and pop may occur in the same cycle.
// Notes: in_ready falls when full; out_valid rises when not empty.

`timescale 1ns/1ps

module dspdla_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);

	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [PTR_W:0] count_q;
	logic push;
	logic pop;

	// ----------------------------------------
	// Handshakes
	// ----------------------------------------
	assign o_in_ready = (count_q != (PTR_W+1)'(DEPTH));
	assign o_out_valid = (count_q != '0);
	assign push = i_in_valid & o_in_ready;
	assign pop = i_out_ready & o_out_valid;
	assign o_out_data = mem_q[rd_ptr_q];

	// Storage array
	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule : dspdla_fifo

// file: tb/dspdla_host.sv
// Purpose: Host model that masters the shared serial port in four-wire and two-wire modes.
// Assumes: Pull-ups on the data and output lines; 160 ns link clock.
// Notes: The link clock idles high and stands still between frames.

`timescale 1ns/1ps

module dspdla_host (
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_sda_drv,
	input wire logic i_sda_line,
	input wire logic i_dout_line
);

	// Idle bus: clock high, frame select high, data released
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_sda_drv = 1'b1;
	end

	// Frame select; data released when the frame ends
	task automatic spi_sel(input logic v);
		o_cs_n = v;
		o_sda_drv = 1'b1;
		#200;
	endtask : spi_sel

	// Four-wire byte: data set on the fall, read back just before the next fall
	task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			o_sclk = 1'b0;
			o_sda_drv = tx[i];
			#80 o_sclk = 1'b1;
			#75 rx[i] = i_dout_line;
			#5;
		end
	endtask : spi_byte

	// Clock pulses with no frame and no start condition
	task automatic idle_clocks(input int n);
		repeat (n) begin
			#80 o_sclk = 1'b0;
			#80 o_sclk = 1'b1;
		end
	endtask : idle_clocks

	// Start condition with the frame select left high
	task automatic i2c_start();
		o_sda_drv = 1'b0;
		#80 o_sclk = 1'b0;
		#80;
	endtask : i2c_start

	// Eight bits then a released ninth bit; data moves only mid-low phase, line read late in each high phase
	task automatic i2c_byte(input logic [7:0] b, output logic ack, output logic [7:0] rd);
		for (int i = 8; i >= 0; i--) begin
			#40 o_sda_drv = (i == 0) ? 1'b1 : b[i-1];
			#40 o_sclk = 1'b1;
			#75 ack = ~i_sda_line;
			if (i > 0) begin
				rd[i-1] = i_sda_line;
			end
			#5 o_sclk = 1'b0;
		end
	endtask : i2c_byte

	// Stop condition
	task automatic i2c_stop();
		#40 o_sda_drv = 1'b0;
		#40 o_sclk = 1'b1;
		#80 o_sda_drv = 1'b1;
		#80;
	endtask : i2c_stop

endmodule : dspdla_host

// file: tb/dspdla_tb.sv
// Purpose: Self-checking bench for the serial port, DAC load and alert block.
// Assumes: Host model on the serial pins; pull-ups on open-drain lines.
// Notes: FIFO depth reduced to 4 so the fill test stays short.

`timescale 1ns/1ps

module dspdla_tb
	import dspdla_pkg::*;
;

	localparam int DEPTH = 4;
	typedef struct packed {
		logic [1:0] sel;
		logic lim;
		logic [6:0] addr;
	} dspdla_row_type;

	logic i_clock = 1'b0;
	logic i_reset = 1'b1;
	logic [1:0] i_addr_sel = 2'h0;
	logic i_dac_load_strobe_n = 1'b1;
	logic i_cfg_wr = 1'b0;
	logic i_cfg_load_pin_enable = 1'b1;
	logic i_cfg_alert_active_high = 1'b0;
	logic i_sw_load = 1'b0;
	dspdla_dac_wr_type i_dac_wr = '0;
	logic i_limit_exceeded = 1'b0;
	logic [7:0] i_tx_data = 8'h00;
	logic i_rx_ready = 1'b0;
	logic i_overrun_clr = 1'b0;
	logic sclk, cs_n, sda_drv, o_sdin_oe, o_dout_oe, o_load_pin_enable, o_alert_active_high;
	logic o_alert_oe, o_rx_valid, o_rx_overrun, o_addr_latched, o_dac_updated, o_sdin_o, o_dout_o, o_alert_o;
	logic [NUM_DAC-1:0][DAC_W-1:0] o_dac_value;
	logic [NUM_DAC-1:0] o_pending;
	dspdla_rx_word_type o_rx_word;
	logic [6:0] o_i2c_addr;
	int compares = 0;
	int miscompares = 0;
	dspdla_row_type rows [3] = '{'{ADD_SEL_LOW, 1'b1, 7'h48}, '{ADD_SEL_FLOAT, 1'b0, 7'h4a},
		'{ADD_SEL_HIGH, 1'b1, 7'h4b}};

	// Open-drain lines with pull-ups
	wire sda_line = sda_drv & (o_sdin_oe ? o_sdin_o : 1'b1);
	wire dout_line = o_dout_oe ? o_dout_o : 1'b1;
	wire alert_line = o_alert_oe ? o_alert_o : 1'b1;

	always #10 i_clock = ~i_clock;

	dspdla_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sda_drv(sda_drv), .i_sda_line(sda_line),
		.i_dout_line(dout_line));

	dspdla_top #(.FIFO_DEPTH(DEPTH)) DUT (.i_clock, .i_reset, .i_sclk(sclk), .i_cs_n(cs_n),
		.i_sdin(sda_line), .o_sdin_o, .o_sdin_oe, .o_dout_o, .o_dout_oe, .i_addr_sel,
		.i_dac_load_strobe_n, .i_cfg_wr, .i_cfg_load_pin_enable, .i_cfg_alert_active_high,
		.o_load_pin_enable, .o_alert_active_high, .i_sw_load, .i_dac_wr, .o_dac_value, .o_pending,
		.o_dac_updated, .i_limit_exceeded, .o_alert_o, .o_alert_oe, .i_tx_data, .o_rx_word,
		.o_rx_valid, .i_rx_ready, .o_rx_overrun, .i_overrun_clr, .o_i2c_addr, .o_addr_latched);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : cyc

	// Check the FIFO head then pop it
	task automatic pop(input logic [8:0] exp);
		chk(o_rx_valid, 1'b1);
		chk(o_rx_word, exp);
		i_rx_ready = 1'b1;
		cyc(1);
		i_rx_ready = 1'b0;
		cyc(1); // Low strobe stands one edge before any next call
	endtask : pop

	task automatic dac_wr(input logic [1:0] sel, input logic [11:0] data);
		i_dac_wr = '{1'b1, sel, data};
		cyc(1);
		i_dac_wr = '0;
		cyc(1); // Low valid stands one edge before any next call
	endtask : dac_wr

	task automatic cfg(input logic lpe, input logic ah);
		i_cfg_load_pin_enable = lpe;
		i_cfg_alert_active_high = ah;
		i_cfg_wr = 1'b1;
		cyc(1);
		i_cfg_wr = 1'b0;
		cyc(1); // Low strobe stands one edge before any next call
	endtask : cfg

	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	// Watchdog
	initial begin
		#500000;
		miscompares++;
		finish_test();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [7:0] rx;
		logic ack;
		int n;
		cyc(3);
		i_reset = 1'b0;
		cyc(4);
		chk(o_load_pin_enable, 1'b1);
		chk(o_alert_active_high, 1'b0);
		chk(o_dout_oe, 1'b0);
		chk(o_pending, 4'h0);
		$display("test reset done");
		// Table: select level and limit against address and alert output enable
		for (int r = 0; r < 3; r++) begin
			i_addr_sel = rows[r].sel;
			i_limit_exceeded = rows[r].lim;
			cyc(5);
			chk(o_i2c_addr, rows[r].addr);
			chk(o_alert_oe, rows[r].lim);
		end
		i_limit_exceeded = 1'b0;
		$display("test table done");
		// Clocks without a frame or start are ignored
		host.idle_clocks(10);
		cyc(3);
		chk(o_rx_valid, 1'b0);
		chk(o_dout_oe, 1'b0);
		$display("test idle done");
		// One four-wire byte each way
		i_tx_data = 8'h3c;
		host.spi_sel(1'b0);
		host.spi_byte(8'ha5, rx);
		host.spi_sel(1'b1);
		cyc(3);
		chk(rx, 8'h3c);
		pop({1'b0, 8'ha5});
		chk(o_dout_oe, 1'b0);
		$display("test spi done");
		// Fill the FIFO past full while the reader stalls, then drain it
		i_tx_data = 8'hff;
		host.spi_sel(1'b0);
		for (int k = 0; k < 5; k++)
			host.spi_byte(8'(8'h10 + k), rx);
		host.spi_sel(1'b1);
		cyc(3);
		chk(o_rx_overrun, 1'b1);
		n = 0;
		while (o_rx_valid === 1'b1 && n < 8) begin
			pop({1'b0, 8'(8'h10 + n)});
			n++;
		end
		chk(16'(n), 16'(DEPTH));
		i_overrun_clr = 1'b1;
		cyc(1);
		i_overrun_clr = 1'b0;
		cyc(1);
		chk(o_rx_overrun, 1'b0);
		$display("test fifo done");
		// Strobe loads two pending channels together
		dac_wr(2'h0, 12'h123);
		dac_wr(2'h2, 12'h456);
		chk(o_pending, 4'h5);
		i_dac_load_strobe_n = 1'b0;
		n = 0;
		while (o_dac_value[0] !== 12'h123 && n < 10) begin
			cyc(1);
			n++;
		end
		chk(o_dac_value[0], 12'h123);
		chk(o_dac_value[2], 12'h456);
		chk(o_dac_value[1], 12'h000);
		chk(o_pending, 4'h0);
		chk(o_dac_updated, 1'b1);
		i_dac_load_strobe_n = 1'b1;
		cyc(4);
		// Strobe refused with the pin disabled; software load still acts
		cfg(1'b0, 1'b0);
		dac_wr(2'h1, 12'h789);
		i_dac_load_strobe_n = 1'b0;
		cyc(8);
		chk(o_dac_value[1], 12'h000);
		chk(o_pending, 4'h2);
		chk(o_dac_updated, 1'b0);
		i_dac_load_strobe_n = 1'b1;
		i_sw_load = 1'b1;
		cyc(1);
		i_sw_load = 1'b0;
		cyc(2);
		chk(o_dac_value[1], 12'h789);
		cfg(1'b1, 1'b0);
		$display("test dac done");
		// Alert with active-high polarity
		cfg(1'b1, 1'b1);
		i_limit_exceeded = 1'b1;
		cyc(3);
		chk(alert_line, 1'b1);
		i_limit_exceeded = 1'b0;
		cyc(3);
		chk(alert_line, 1'b0);
		cfg(1'b1, 1'b0);
		$display("test alert done");
		// Two-wire: address latches only on the second matching addressing
		i_addr_sel = ADD_SEL_HIGH;
		cyc(4);
		host.i2c_start();
		host.i2c_byte(8'h96, ack, rx);
		chk(ack, 1'b1);
		host.i2c_byte(8'h5a, ack, rx);
		chk(ack, 1'b1);
		host.i2c_stop();
		cyc(2);
		chk(o_addr_latched, 1'b0);
		pop({1'b1, 8'h5a});
		host.i2c_start();
		host.i2c_byte(8'h96, ack, rx);
		host.i2c_stop();
		cyc(2);
		chk(o_addr_latched, 1'b1);
		i_addr_sel = ADD_SEL_LOW;
		i_tx_data = 8'h6c;
		cyc(6);
		chk(o_i2c_addr, 7'h4b);
		// After the latch the new pin address is ignored; a read at the latched one answers
		host.i2c_start();
		host.i2c_byte(8'h90, ack, rx);
		host.i2c_stop();
		chk(ack, 1'b0);
		host.i2c_start();
		host.i2c_byte(8'h97, ack, rx);
		chk(ack, 1'b1);
		host.i2c_byte(8'hff, ack, rx);
		host.i2c_stop();
		chk(rx, 8'h6c);
		chk(ack, 1'b0);
		$display("test i2c done");
		finish_test();
	end

endmodule : dspdla_tb
